/* File: design/gate_mode_logic.sv */
`timescale 1ns/100ps
module gate_mode_logic
    import gate_mode_pkg::*;
#(
    parameter int PWM_ACT_CYC  = PWM_TS_ACT_CYC,
    parameter int SEL_ACT_CYC  = SEL_TS_ACT_CYC,
    parameter int FCCM_CYC     = FCCM_HOLD_CYC,
    parameter int WAKE_CYCLES  = WAKE_CYC
) (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // comparator inputs from pins
    input  wire gate_mode_pkg::tri_level_t pwm_level,
    input  wire gate_mode_pkg::tri_level_t mode_select_level,
    input  wire logic                    supply_lockout,
    input  wire logic                    zero_cross_detect,
    // gate and mode outputs
    output gate_mode_pkg::gate_out_t     gate_out,
    output gate_mode_pkg::mode_t         mode_state
);
    import gate_mode_pkg::*;

    typedef struct packed {
        tri_level_t pwm_s1;
        tri_level_t pwm_s2;
        tri_level_t sel_s1;
        tri_level_t sel_s2;
        logic       lo_s1;
        logic       lo_s2;
        logic       zx_s1;
        logic       zx_s2;
        level_t     pwm_dec;
        level_t     sel_dec;
        logic [CNT_W-1:0] pwm_tcnt;
        logic [CNT_W-1:0] sel_tcnt;
        logic [CNT_W-1:0] fccm_cnt;
        logic [CNT_W-1:0] wake_cnt;
        logic       zx_seen;
        logic       lockout_held;
        mode_t      mode;
        gate_out_t  gates;
    } state_t;

    state_t state_reg;
    state_t state_next;
    level_t pwm_raw;
    level_t sel_raw;
    logic   hs_en;
    logic   ls_en;
    logic   zx_on;

    function automatic level_t classify(input tri_level_t l);
        if (l.above_high) begin
            return LVL_HIGH;
        end else if (l.above_low) begin
            return LVL_TRI;
        end
        return LVL_LOW;
    endfunction : classify

    always_comb begin
        state_next        = state_reg;
        state_next.pwm_s1 = pwm_level;
        state_next.pwm_s2 = state_reg.pwm_s1;
        state_next.sel_s1 = mode_select_level;
        state_next.sel_s2 = state_reg.sel_s1;
        state_next.lo_s1  = supply_lockout;
        state_next.lo_s2  = state_reg.lo_s1;
        state_next.zx_s1  = zero_cross_detect;
        state_next.zx_s2  = state_reg.zx_s1;
        pwm_raw = classify(state_reg.pwm_s2);
        sel_raw = classify(state_reg.sel_s2);
        hs_en   = 1'b0;
        ls_en   = 1'b0;
        zx_on   = 1'b0;

        // lockout comparator is off in ulq, so the lockout level is frozen there
        if (state_reg.mode != MODE_ULQ) begin
            state_next.lockout_held = state_reg.lo_s2;
        end

        // pwm: high/low act at once, tri-state only after dwell
        if (pwm_raw != LVL_TRI) begin
            state_next.pwm_tcnt = '0;
            state_next.pwm_dec  = pwm_raw;
        end else if (state_reg.pwm_tcnt >= CNT_W'(PWM_ACT_CYC - 1)) begin
            state_next.pwm_dec  = LVL_TRI;
        end else begin
            state_next.pwm_tcnt = state_reg.pwm_tcnt + 1'b1;
        end
        if (sel_raw != LVL_TRI) begin
            state_next.sel_tcnt = '0;
            state_next.sel_dec  = sel_raw;
        end else if (state_reg.sel_tcnt >= CNT_W'(SEL_ACT_CYC - 1)) begin
            state_next.sel_dec  = LVL_TRI;
        end else begin
            state_next.sel_tcnt = state_reg.sel_tcnt + 1'b1;
        end

        // forced ccm after pwm leaves tri-state
        if (state_reg.pwm_dec == LVL_TRI && state_next.pwm_dec != LVL_TRI) begin
            state_next.fccm_cnt = CNT_W'(FCCM_CYC);
        end else if (state_reg.fccm_cnt != '0) begin
            state_next.fccm_cnt = state_reg.fccm_cnt - 1'b1;
        end

        if (state_reg.wake_cnt != '0) begin
            state_next.wake_cnt = state_reg.wake_cnt - 1'b1;
        end

        if (state_reg.lockout_held && state_reg.mode != MODE_ULQ) begin
            state_next.mode     = MODE_DISABLED;
            state_next.wake_cnt = '0;
            state_next.fccm_cnt = '0;
        end else if (state_reg.sel_dec == LVL_TRI) begin
            state_next.mode = MODE_ULQ;
        end else if (state_reg.mode == MODE_ULQ) begin
            state_next.mode     = MODE_WAKE;
            state_next.wake_cnt = CNT_W'(WAKE_CYCLES - 1);
        end else if (state_reg.mode == MODE_WAKE && state_reg.wake_cnt != '0) begin
            state_next.mode = MODE_WAKE;
        end else if (state_reg.pwm_dec == LVL_TRI) begin
            state_next.mode = MODE_LQ;
        end else if (state_reg.sel_dec == LVL_HIGH || state_reg.fccm_cnt != '0) begin
            state_next.mode = MODE_FCCM;
        end else begin
            state_next.mode = MODE_DCM;
        end

        // gate decode from the registered mode, pwm valid in fccm and dcm only
        unique case (state_reg.mode)
            MODE_FCCM: begin
                hs_en = (state_reg.pwm_dec == LVL_HIGH);
                ls_en = (state_reg.pwm_dec == LVL_LOW);
            end
            MODE_DCM: begin
                zx_on = 1'b1;
                hs_en = (state_reg.pwm_dec == LVL_HIGH);
                ls_en = (state_reg.pwm_dec == LVL_LOW) && !state_reg.zx_seen && !state_reg.zx_s2;
            end
            MODE_DISABLED, MODE_LQ, MODE_ULQ, MODE_WAKE: begin
                hs_en = 1'b0;
                ls_en = 1'b0;
            end
        endcase

        // zero-cross latch, cleared when pwm goes high or tri-state
        if (state_reg.pwm_dec != LVL_LOW) begin
            state_next.zx_seen = 1'b0;
        end else if (zx_on && state_reg.zx_s2) begin
            state_next.zx_seen = 1'b1;
        end

        state_next.gates.high_side_gate_enable = hs_en;
        state_next.gates.low_side_gate_enable  = ls_en;
        state_next.gates.boot_switch_enable    = ls_en;
        state_next.gates.zero_cross_enable     = zx_on;
        state_next.gates.lockout_comp_enable   = (state_reg.mode != MODE_ULQ);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // lockout taken as active until the synchronised pin says otherwise
            state_reg              <= '0;
            state_reg.lo_s1        <= 1'b1;
            state_reg.lo_s2        <= 1'b1;
            state_reg.lockout_held <= 1'b1;
            state_reg.pwm_dec      <= LVL_TRI;
            state_reg.sel_dec      <= LVL_LOW;
            state_reg.mode         <= MODE_DISABLED;
            state_reg.gates        <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign gate_out   = state_reg.gates;
    assign mode_state = state_reg.mode;

    lockout_gates_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg.mode == MODE_DISABLED |=> !gate_out.high_side_gate_enable && !gate_out.low_side_gate_enable)
        else $error("gates on while disabled");
    lockout_enter_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg.lockout_held && state_reg.mode != MODE_ULQ |=> state_reg.mode == MODE_DISABLED)
        else $error("lockout did not disable");
    lq_gates_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg.mode == MODE_LQ |=> !gate_out.high_side_gate_enable && !gate_out.low_side_gate_enable
        && !gate_out.boot_switch_enable && !gate_out.zero_cross_enable)
        else $error("gates on in low quiescent");
    no_overlap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(gate_out.high_side_gate_enable && gate_out.low_side_gate_enable))
        else $error("shoot-through");
    boot_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        gate_out.boot_switch_enable == gate_out.low_side_gate_enable)
        else $error("boot switch mismatch");
    fccm_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg.pwm_dec == LVL_TRI && state_next.pwm_dec == LVL_LOW && !state_reg.lockout_held
        && state_reg.sel_dec == LVL_LOW && state_reg.mode == MODE_LQ |=> ##1 state_reg.mode == MODE_FCCM)
        else $error("no forced ccm after tri-state exit");
    pwm_dwell_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(state_reg.pwm_dec == LVL_TRI) |-> $past(pwm_raw) == LVL_TRI
        && $past(pwm_raw, PWM_ACT_CYC) == LVL_TRI)
        else $error("pwm tri-state too early");
    ulq_comp_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg.mode == MODE_ULQ |=> !gate_out.lockout_comp_enable)
        else $error("lockout comparator on in ulq");
    dcm_zx_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg.mode == MODE_DCM && state_reg.zx_s2 |=> !gate_out.low_side_gate_enable)
        else $error("low side on after zero cross");

endmodule : gate_mode_logic

/* File: design/gate_mode_pkg.sv */
package gate_mode_pkg;

    // timing, 100 MHz system clock
    localparam int CLK_PERIOD_NS    = 10;
    localparam int PWM_TS_ACT_NS    = 60;
    localparam int SEL_TS_ACT_US    = 1;
    localparam int FCCM_HOLD_US     = 4;
    localparam int WAKE_US          = 50;
    localparam int PWM_TS_ACT_CYC   = (PWM_TS_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEL_TS_ACT_CYC   = (SEL_TS_ACT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FCCM_HOLD_CYC    = (FCCM_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYC         = (WAKE_US * 1000) / CLK_PERIOD_NS;
    localparam int CNT_W            = 13;

    // three-level input as two comparator bits
    typedef struct packed {
        logic above_high;
        logic above_low;
    } tri_level_t;

    typedef enum logic [1:0] {
        LVL_LOW,
        LVL_HIGH,
        LVL_TRI
    } level_t;

    typedef enum logic [2:0] {
        MODE_DISABLED,
        MODE_DCM,
        MODE_FCCM,
        MODE_LQ,
        MODE_ULQ,
        MODE_WAKE
    } mode_t;

    typedef struct packed {
        logic high_side_gate_enable;
        logic low_side_gate_enable;
        logic boot_switch_enable;
        logic zero_cross_enable;
        logic lockout_comp_enable;
    } gate_out_t;

endpackage : gate_mode_pkg

/* File: testbench/pwm_ctrl_model.sv */
`timescale 1ns/100ps
module pwm_ctrl_model #(
    parameter int WAKE_CYCLES = 16
) (
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    // level requests from the bench
    input  wire gate_mode_pkg::level_t     pwm_cmd,
    input  wire gate_mode_pkg::level_t     sel_cmd,
    // pins toward the stage
    output gate_mode_pkg::tri_level_t      pwm_level,
    output gate_mode_pkg::tri_level_t      mode_select_level
);
    import gate_mode_pkg::*;
    int wake_reg;
    function automatic tri_level_t enc(input level_t l);
        return (l == LVL_HIGH) ? 2'h3 : ((l == LVL_TRI) ? 2'h1 : 2'h0);
    endfunction : enc
    // no pulses until the wake interval after leaving select tri-state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wake_reg <= 0;
        end else if (sel_cmd == LVL_TRI) begin
            wake_reg <= WAKE_CYCLES;
        end else if (wake_reg > 0) begin
            wake_reg <= wake_reg - 1;
        end
    end
    assign mode_select_level = enc(sel_cmd);
    assign pwm_level         = (wake_reg > 0) ? enc(LVL_TRI) : enc(pwm_cmd);
endmodule : pwm_ctrl_model

/* File: testbench/tb.sv */
`timescale 1ns/100ps
module tb;
    import gate_mode_pkg::*;
    typedef struct packed {
        gate_out_t val;
        gate_out_t msk;
        mode_t     mode;
    } note_t;
    localparam gate_out_t G_ALL = 5'h1f;
    localparam gate_out_t G_DRV = 5'h1c;
    logic       clk_sys, rst_n, supply_lockout, zero_cross_detect, chk, b;
    level_t     pwm_cmd, sel_cmd;
    tri_level_t pwm_level, mode_select_level;
    gate_out_t  gate_out;
    mode_t      mode_state;
    note_t      notes[$];
    note_t      cur;
    int         err_total, num_checks;

    pwm_ctrl_model #(.WAKE_CYCLES(16)) ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .pwm_cmd(pwm_cmd),
        .sel_cmd(sel_cmd), .pwm_level(pwm_level), .mode_select_level(mode_select_level));
    gate_mode_logic #(.PWM_ACT_CYC(2), .SEL_ACT_CYC(4), .FCCM_CYC(8), .WAKE_CYCLES(16)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .pwm_level(pwm_level), .mode_select_level(mode_select_level),
        .supply_lockout(supply_lockout), .zero_cross_detect(zero_cross_detect),
        .gate_out(gate_out), .mode_state(mode_state));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    // bounded wait for the mode, then note the expected outputs
    task automatic expect_state(input mode_t m, input gate_out_t v, input gate_out_t k);
        int n;
        n = 0;
        repeat (5) @(posedge clk_sys);
        while (mode_state !== m && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 100) begin
            err_total++;
            test_done();
        end
        @(posedge clk_sys);
        notes.push_back('{v, k, m});
        chk <= 1'b1;
        @(posedge clk_sys);
        chk <= 1'b0;
    endtask : expect_state

    always @(posedge clk_sys) begin
        if (chk) begin
            cur = notes.pop_front();
            check({3'h0, gate_out & cur.msk}, {3'h0, cur.val}, "gate_out");
            check({5'h0, mode_state}, {5'h0, cur.mode}, "mode_state");
        end
    end

    initial begin
        void'($urandom(32'h7c998bf9));
        err_total = 0;
        num_checks = 0;
        chk = 1'b0;
        rst_n = 1'b0;
        supply_lockout = 1'b1;
        zero_cross_detect = 1'b0;
        pwm_cmd = LVL_HIGH;
        sel_cmd = LVL_HIGH;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        expect_state(MODE_DISABLED, 5'h00, G_DRV);
        supply_lockout <= 1'b0;
        expect_state(MODE_FCCM, 5'h11, G_ALL);
        pwm_cmd <= LVL_LOW;
        expect_state(MODE_FCCM, 5'h0d, G_ALL);
        pwm_cmd <= LVL_TRI;
        expect_state(MODE_LQ, 5'h00, G_DRV);
        pwm_cmd <= LVL_LOW;
        sel_cmd <= LVL_LOW;
        expect_state(MODE_FCCM, 5'h0c, G_DRV);
        expect_state(MODE_DCM, 5'h0f, G_ALL);
        zero_cross_detect <= 1'b1;
        expect_state(MODE_DCM, 5'h03, G_ALL);
        zero_cross_detect <= 1'b0;
        pwm_cmd <= LVL_TRI;
        sel_cmd <= LVL_TRI;
        expect_state(MODE_ULQ, 5'h00, 5'h1d);
        sel_cmd <= LVL_LOW;
        pwm_cmd <= LVL_HIGH;
        expect_state(MODE_WAKE, 5'h00, G_DRV);
        expect_state(MODE_DCM, 5'h10, G_DRV);
        sel_cmd <= LVL_HIGH;
        for (int i = 0; i < 8; i++) begin
            b = 1'($urandom());
            pwm_cmd <= b ? LVL_HIGH : LVL_LOW;
            expect_state(MODE_FCCM, b ? 5'h11 : 5'h0d, G_ALL);
        end
        supply_lockout <= 1'b1;
        expect_state(MODE_DISABLED, 5'h00, G_DRV);
        test_done();
    end
endmodule : tb
